// ---- verilog/two_level_interrupt_unit.sv ----
// Chosen here: register access over Wishbone.
module two_level_interrupt_unit #(
   parameter int CYCLE_CLKS = irq_pkg::CYCLE_CLKS
) (
   input wire logic clk_i,                 // System clock, 40 MHz.
   input wire logic rst_i,                 // Synchronous reset, active high.
   input wire logic [7:0] adr_i,           // Wishbone byte address.
   input wire logic [31:0] dat_i,          // Wishbone write data.
   output logic [31:0] dat_o,              // Wishbone read data.
   input wire logic we_i,                  // Wishbone write enable.
   input wire logic [3:0] sel_i,           // Wishbone byte selects.
   input wire logic cyc_i,                 // Wishbone cycle.
   input wire logic stb_i,                 // Wishbone strobe.
   output logic ack_o,                     // Wishbone acknowledge.
   input wire logic ext_request_pin_0_i,   // External request pin 0, low active.
   input wire logic ext_request_pin_1_i,   // External request pin 1, low active.
   input wire irq_pkg::src_events_t src_i, // Peripheral event pulses.
   output irq_pkg::grant_t grant_o,        // Request offered to the core.
   input wire logic take_i,                // Core vectors to grant_o this cycle.
   input wire logic return_i,              // Core leaves its current routine.
   output logic irq_o                      // Enabled block event pending.
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] cyc_cnt;
   logic tick;
   logic [irq_pkg::NUM_FLAGS-1:0] flags;
   logic [15:0] enable;
   logic [irq_pkg::NUM_SRC-1:0] prio;
   logic [1:0] trig;
   logic [irq_pkg::NUM_EV-1:0] ev_status;
   logic [irq_pkg::NUM_EV-1:0] ev_enable;
   irq_pkg::svc_state_t svc;
   irq_pkg::svc_state_t next_svc;
   irq_pkg::grant_t next_grant;
   logic ext0_fall;
   logic ext0_low;
   logic ext1_fall;
   logic ext1_low;
   logic [irq_pkg::NUM_SRC-1:0] src_flag;
   logic [irq_pkg::NUM_SRC-1:0] req;
   logic hi_valid;
   logic lo_valid;
   logic [irq_pkg::IDX_W-1:0] hi_index;
   logic [irq_pkg::IDX_W-1:0] lo_index;
   logic bus_req;
   logic wr;
   logic [31:0] wmask;
   logic [irq_pkg::NUM_FLAGS-1:0] next_flags;
   logic [irq_pkg::NUM_EV-1:0] ev_set;
   logic [31:0] rdata;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cyc_cnt <= 8'h00;
      end else if (tick) begin
         cyc_cnt <= 8'h00;
      end else begin
         cyc_cnt <= cyc_cnt + 8'h01;
      end
   end
   assign tick = (cyc_cnt == 8'(CYCLE_CLKS - 1));

   pin_fall_sampler u_ext0 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(ext_request_pin_0_i),
      .tick_i(tick),
      .fall_o(ext0_fall),
      .low_o(ext0_low)
   );

   pin_fall_sampler u_ext1 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(ext_request_pin_1_i),
      .tick_i(tick),
      .fall_o(ext1_fall),
      .low_o(ext1_low)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Classic Wishbone: one wait state, unmapped addresses answer zero.
   assign bus_req = cyc_i & stb_i;
   assign wr = bus_req & we_i & ack_o;
   assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= bus_req & ~ack_o;
      end
   end

   always_comb begin
      rdata = 32'h0000_0000;
      case (adr_i)
         irq_pkg::OFF_FLAGS: rdata[irq_pkg::NUM_FLAGS-1:0] = flags;
         irq_pkg::OFF_ENABLE: rdata[15:0] = enable;
         irq_pkg::OFF_PRIO: rdata[irq_pkg::NUM_SRC-1:0] = prio;
         irq_pkg::OFF_TRIG: rdata[1:0] = trig;
         irq_pkg::OFF_GRANT: rdata[23:0] = {svc, grant_o};
         irq_pkg::OFF_EV_STATUS: rdata[irq_pkg::NUM_EV-1:0] = ev_status;
         irq_pkg::OFF_EV_ENABLE: rdata[irq_pkg::NUM_EV-1:0] = ev_enable;
         irq_pkg::OFF_WATCHDOG_CONTROL_REG: rdata[irq_pkg::WATCHDOG_CONTROL_REG_WATCHDOG_TIMEOUT_FLAG_BIT] = flags[irq_pkg::FLG_WATCHDOG_TIMEOUT_FLAG];
         default: rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (bus_req & ~ack_o) begin
         dat_o <= rdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable <= irq_pkg::ENABLE_RST;
         prio <= irq_pkg::PRIO_RST;
         trig <= irq_pkg::TRIG_RST;
         ev_enable <= irq_pkg::EV_RST;
      end else if (wr) begin
         case (adr_i)
            irq_pkg::OFF_ENABLE: enable <= (enable & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
            irq_pkg::OFF_PRIO: begin
               prio <= (prio & ~wmask[9:0]) | (dat_i[9:0] & wmask[9:0]);
            end
            irq_pkg::OFF_TRIG: trig <= (trig & ~wmask[1:0]) | (dat_i[1:0] & wmask[1:0]);
            irq_pkg::OFF_EV_ENABLE: begin
               ev_enable <= (ev_enable & ~wmask[3:0]) | (dat_i[3:0] & wmask[3:0]);
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software write first, then hardware clears on vectoring, then hardware sets, so a set
   // arriving in the cycle of a clear is never lost.
   always_comb begin
      next_flags = flags;
      if (wr && adr_i == irq_pkg::OFF_FLAGS) begin
         next_flags = (flags & ~wmask[11:0]) | (dat_i[11:0] & wmask[11:0]);
      end
      if (wr && adr_i == irq_pkg::OFF_WATCHDOG_CONTROL_REG && wmask[irq_pkg::WATCHDOG_CONTROL_REG_WATCHDOG_TIMEOUT_FLAG_BIT]) begin
         next_flags[irq_pkg::FLG_WATCHDOG_TIMEOUT_FLAG] = dat_i[irq_pkg::WATCHDOG_CONTROL_REG_WATCHDOG_TIMEOUT_FLAG_BIT];
      end
      if (take_i && grant_o.req) begin
         case (int'(grant_o.index))
            irq_pkg::SRC_EXT0: if (!trig[0]) next_flags[irq_pkg::FLG_EXT0] = 1'b0;
            irq_pkg::SRC_EXT1: if (!trig[1]) next_flags[irq_pkg::FLG_EXT1] = 1'b0;
            irq_pkg::SRC_T0: next_flags[irq_pkg::FLG_T0] = 1'b0;
            irq_pkg::SRC_T1: next_flags[irq_pkg::FLG_T1] = 1'b0;
            default: begin
               // Timer 2, serial, converter, bus channels and watchdog stay set.
            end
         endcase
      end
      // Edge mode flags a falling sample pair; level mode follows a low sample.
      if (trig[0] ? ext0_low : ext0_fall) next_flags[irq_pkg::FLG_EXT0] = 1'b1;
      if (trig[1] ? ext1_low : ext1_fall) next_flags[irq_pkg::FLG_EXT1] = 1'b1;
      if (src_i.timer0_ovf) next_flags[irq_pkg::FLG_T0] = 1'b1;
      if (src_i.timer1_ovf) next_flags[irq_pkg::FLG_T1] = 1'b1;
      if (src_i.rx_done) next_flags[irq_pkg::FLG_RX] = 1'b1;
      if (src_i.tx_done) next_flags[irq_pkg::FLG_TX] = 1'b1;
      if (src_i.timer2_ovf) next_flags[irq_pkg::FLG_T2OVF] = 1'b1;
      if (src_i.timer2_evt) next_flags[irq_pkg::FLG_T2EVT] = 1'b1;
      if (src_i.adc_done) next_flags[irq_pkg::FLG_ADC] = 1'b1;
      if (src_i.bus1_state) next_flags[irq_pkg::FLG_BUS1] = 1'b1;
      if (src_i.bus2_state) next_flags[irq_pkg::FLG_BUS2] = 1'b1;
      if (src_i.wdt_timeout) next_flags[irq_pkg::FLG_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags <= irq_pkg::FLAGS_RST;
      end else begin
         flags <= next_flags;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign src_flag = {flags[11], flags[10], flags[9], flags[8], flags[7] | flags[6],
      flags[5] | flags[4], flags[3], flags[2], flags[1], flags[0]};
   // The global gate overrides every individual enable.
   assign req = src_flag & enable[irq_pkg::NUM_SRC-1:0] & {10{enable[irq_pkg::ENA_GLOBAL_BIT]}};

   fixed_priority_pick #(.N(irq_pkg::NUM_SRC), .IW(irq_pkg::IDX_W)) u_pick_hi (
      .req_i(req & prio),
      .valid_o(hi_valid),
      .index_o(hi_index)
   );

   fixed_priority_pick #(.N(irq_pkg::NUM_SRC), .IW(irq_pkg::IDX_W)) u_pick_lo (
      .req_i(req & ~prio),
      .valid_o(lo_valid),
      .index_o(lo_index)
   );

   // The offer is withheld in the take cycle so a stale flag cannot be offered twice.
   always_comb begin
      next_grant = '0;
      if (!take_i) begin
         if (hi_valid && (svc == irq_pkg::SVC_IDLE || svc == irq_pkg::SVC_LOW)) begin
            next_grant.req = 1'b1;
            next_grant.high = 1'b1;
            next_grant.index = hi_index;
         end else if (lo_valid && svc == irq_pkg::SVC_IDLE) begin
            next_grant.req = 1'b1;
            next_grant.index = lo_index;
         end
         if (next_grant.req) begin
            next_grant.vector = irq_pkg::VECTOR[next_grant.index];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         grant_o <= '0;
      end else begin
         grant_o <= next_grant;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_svc = svc;
      if (take_i && grant_o.req) begin
         if (!grant_o.high) begin
            next_svc = irq_pkg::SVC_LOW;
         end else if (svc == irq_pkg::SVC_LOW) begin
            next_svc = irq_pkg::SVC_HIGH_OVER_LOW;
         end else begin
            next_svc = irq_pkg::SVC_HIGH;
         end
      end else if (return_i) begin
         case (svc)
            irq_pkg::SVC_HIGH_OVER_LOW: next_svc = irq_pkg::SVC_LOW;
            irq_pkg::SVC_HIGH: next_svc = irq_pkg::SVC_IDLE;
            irq_pkg::SVC_LOW: next_svc = irq_pkg::SVC_IDLE;
            default: next_svc = irq_pkg::SVC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         svc <= irq_pkg::SVC_IDLE;
      end else begin
         svc <= next_svc;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      ev_set = '0;
      ev_set[irq_pkg::EV_TAKE] = take_i & grant_o.req;
      ev_set[irq_pkg::EV_PREEMPT] = take_i & grant_o.req & grant_o.high
         & (svc == irq_pkg::SVC_LOW);
      ev_set[irq_pkg::EV_EXT0] = ext0_fall;
      ev_set[irq_pkg::EV_EXT1] = ext1_fall;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_status <= irq_pkg::EV_RST;
      end else if (wr && adr_i == irq_pkg::OFF_EV_CLEAR) begin
         ev_status <= (ev_status & ~(dat_i[3:0] & wmask[3:0])) | ev_set;
      end else begin
         ev_status <= ev_status | ev_set;
      end
   end

   assign irq_o = |(ev_status & ev_enable);

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic wr_flags;
   assign wr_flags = wr && (adr_i == irq_pkg::OFF_FLAGS || adr_i == irq_pkg::OFF_WATCHDOG_CONTROL_REG);

   a_edge_sets_flag: assert property (ext0_fall && !trig[0] |=> flags[irq_pkg::FLG_EXT0])
      else $error("ext0 falling sample did not set its flag");
   a_edge_autoclear: assert property (take_i && grant_o.req && grant_o.index == 4'h0
      && !trig[0] && !ext0_fall && !wr_flags |=> !flags[irq_pkg::FLG_EXT0])
      else $error("edge mode ext0 flag not cleared on vectoring");
   a_level_kept: assert property (take_i && grant_o.req && grant_o.index == 4'h2
      && trig[1] && flags[irq_pkg::FLG_EXT1] && !wr_flags |=> flags[irq_pkg::FLG_EXT1])
      else $error("level mode ext1 flag cleared on vectoring");
   a_timer_clear: assert property (take_i && grant_o.req && grant_o.index == 4'h1
      && !src_i.timer0_ovf && !wr_flags |=> !flags[irq_pkg::FLG_T0])
      else $error("timer 0 flag not cleared on vectoring");
   a_timer2_kept: assert property (take_i && grant_o.index == 4'h5
      && flags[irq_pkg::FLG_T2OVF] && !wr_flags |=> flags[irq_pkg::FLG_T2OVF])
      else $error("timer 2 flag cleared by hardware");
   a_adc_set: assert property (src_i.adc_done |=> flags[irq_pkg::FLG_ADC])
      else $error("converter done flag not set");
   a_wdt_visible: assert property (bus_req && !ack_o && adr_i == irq_pkg::OFF_WATCHDOG_CONTROL_REG
      && flags[irq_pkg::FLG_WATCHDOG_TIMEOUT_FLAG] |=> dat_o[irq_pkg::WATCHDOG_CONTROL_REG_WATCHDOG_TIMEOUT_FLAG_BIT])
      else $error("watchdog flag not visible in watchdog register");
   a_sw_withdraw: assert property (wr && adr_i == irq_pkg::OFF_FLAGS && sel_i[1]
      && !dat_i[11] && !src_i.wdt_timeout |=> !flags[irq_pkg::FLG_WATCHDOG_TIMEOUT_FLAG])
      else $error("software zero did not withdraw watchdog flag");
   a_gate_blocks: assert property (!enable[irq_pkg::ENA_GLOBAL_BIT] |=> !grant_o.req)
      else $error("request offered with global gate clear");
   a_order_first: assert property (flags[0] && enable[0] && (prio[0] || prio == '0)
      && enable[irq_pkg::ENA_GLOBAL_BIT] && svc == irq_pkg::SVC_IDLE && !take_i |=> grant_o.req
      && grant_o.index == 4'h0) else $error("ext0 not served first");
   a_vector_fixed: assert property (grant_o.req && grant_o.index == 4'h9
      |-> grant_o.vector == 16'h0063)
      else $error("watchdog vector wrong");
   a_no_equal_preempt: assert property (svc[1] && !return_i |=> !grant_o.req)
      else $error("routine preempted by equal or higher priority");

   c_preempt: cover property (take_i && grant_o.high && svc == irq_pkg::SVC_LOW);
   c_ext0_taken: cover property (ext0_fall ##[1:4] (take_i && grant_o.index == 4'h0));
   c_level_rearm: cover property (trig[1] && take_i && grant_o.index == 4'h2 ##1 flags[2]);
endmodule

// ---- include/irq_pkg.sv ----
package irq_pkg;
   localparam int NUM_SRC = 10;
   localparam int IDX_W = 4;
   localparam int NUM_FLAGS = 12;
   localparam int NUM_EV = 4;
   // System clocks per machine cycle; the faster turbo rate uses 4.
   localparam int CYCLE_CLKS = 12;

   localparam logic [7:0] OFF_FLAGS = 8'h00;
   localparam logic [7:0] OFF_ENABLE = 8'h04;
   localparam logic [7:0] OFF_PRIO = 8'h08;
   localparam logic [7:0] OFF_TRIG = 8'h0c;
   localparam logic [7:0] OFF_GRANT = 8'h10;
   localparam logic [7:0] OFF_EV_STATUS = 8'h14;
   localparam logic [7:0] OFF_EV_CLEAR = 8'h18;
   localparam logic [7:0] OFF_EV_ENABLE = 8'h1c;
   localparam logic [7:0] OFF_WATCHDOG_CONTROL_REG = 8'hd8;

   localparam int SRC_EXT0 = 0;
   localparam int SRC_T0 = 1;
   localparam int SRC_EXT1 = 2;
   localparam int SRC_T1 = 3;
   localparam int SRC_ADC = 6;
   localparam int SRC_WDT = 9;

   localparam int FLG_EXT0 = 0;
   localparam int FLG_T0 = 1;
   localparam int FLG_EXT1 = 2;
   localparam int FLG_T1 = 3;
   localparam int FLG_RX = 4;
   localparam int FLG_TX = 5;
   localparam int FLG_T2OVF = 6;
   localparam int FLG_T2EVT = 7;
   localparam int FLG_ADC = 8;
   localparam int FLG_BUS1 = 9;
   localparam int FLG_BUS2 = 10;
   localparam int FLG_WATCHDOG_TIMEOUT_FLAG = 11;

   localparam int ENA_GLOBAL_BIT = 15;
   localparam int WATCHDOG_CONTROL_REG_WATCHDOG_TIMEOUT_FLAG_BIT = 3;
   localparam int EV_TAKE = 0;
   localparam int EV_PREEMPT = 1;
   localparam int EV_EXT0 = 2;
   localparam int EV_EXT1 = 3;

   localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 12'h000;
   localparam logic [15:0] ENABLE_RST = 16'h0000;
   localparam logic [NUM_SRC-1:0] PRIO_RST = 10'h000;
   localparam logic [1:0] TRIG_RST = 2'h0;
   localparam logic [NUM_EV-1:0] EV_RST = 4'h0;

   localparam logic [15:0] VECTOR [NUM_SRC] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
      16'h0023, 16'h002b, 16'h0033, 16'h003b, 16'h0043, 16'h0063};

   typedef enum logic [1:0] {
      SVC_IDLE = 2'b00,
      SVC_LOW = 2'b01,
      SVC_HIGH = 2'b10,
      SVC_HIGH_OVER_LOW = 2'b11
   } svc_state_t;

   typedef struct packed {
      logic timer0_ovf;
      logic timer1_ovf;
      logic timer2_ovf;
      logic timer2_evt;
      logic rx_done;
      logic tx_done;
      logic adc_done;
      logic bus1_state;
      logic bus2_state;
      logic wdt_timeout;
   } src_events_t;

   typedef struct packed {
      logic req;
      logic high;
      logic [IDX_W-1:0] index;
      logic [15:0] vector;
   } grant_t;
endpackage

// ---- verilog/pin_fall_sampler.sv ----
module pin_fall_sampler (
   input wire logic clk_i,   // System clock.
   input wire logic rst_i,   // Synchronous reset, active high.
   input wire logic pin_i,   // Asynchronous request pin, low active.
   input wire logic tick_i,  // Machine cycle enable pulse.
   output logic fall_o,      // One-cycle pulse: high sample then low sample.
   output logic low_o        // Level: last machine cycle sample was low.
);
   logic [2:0] sync;
   logic stable;
   logic prev;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync <= 3'h7;
      end else begin
         sync <= {sync[1:0], pin_i};
      end
   end

   // A change counts only once the second and third stages agree.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stable <= 1'b1;
      end else if (sync[1] == sync[2]) begin
         stable <= sync[2];
      end
   end

   // Pulses shorter than a machine cycle may be missed; the requester must hold each level.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev <= 1'b1;
         fall_o <= 1'b0;
         low_o <= 1'b0;
      end else if (tick_i) begin
         prev <= stable;
         fall_o <= prev & ~stable;
         low_o <= ~stable;
      end else begin
         fall_o <= 1'b0;
      end
   end
endmodule

// ---- verilog/fixed_priority_pick.sv ----
module fixed_priority_pick #(
   parameter int N = 10,
   parameter int IW = 4
) (
   input wire logic [N-1:0] req_i,  // Competing requests, bit 0 strongest.
   output logic valid_o,            // Any request present.
   output logic [IW-1:0] index_o    // Lowest set bit.
);
   always_comb begin
      valid_o = |req_i;
      index_o = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req_i[i]) begin
            index_o = IW'(i);
         end
      end
   end
endmodule

// ---- tb/core_model.sv ----
module core_model (
   input wire logic clk_i, // System clock.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire irq_pkg::grant_t grant_i, // Offer from the unit.
   input wire logic [3:0] lag_i, // Cycles to wait before taking.
   output logic take_o, // Vector pulse.
   output logic [19:0] taken_o, // Index and vector last taken.
   output logic [7:0] n_taken_o // Count of takes.
);
   logic [3:0] wait_cnt;
   // A take counts only if the offer still stands at the edge that samples it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         take_o <= 1'b0;
         wait_cnt <= 4'h0;
         taken_o <= 20'h00000;
         n_taken_o <= 8'h00;
      end else if (take_o) begin
         take_o <= 1'b0;
         wait_cnt <= 4'h0;
         if (grant_i.req) begin
            taken_o <= {grant_i.index, grant_i.vector};
            n_taken_o <= n_taken_o + 8'h01;
         end
      end else if (grant_i.req && wait_cnt >= lag_i) begin
         take_o <= 1'b1;
      end else begin
         wait_cnt <= grant_i.req ? wait_cnt + 4'h1 : 4'h0;
      end
   end
endmodule

// ---- tb/tb.sv ----
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [9:0] ev;
      logic [19:0] tk;
      logic [11:0] fl;
   } row_t;
   // The flags column is what must survive the take.
   row_t rows [10] = '{
      '{10'h200, 20'h1000b, 12'h000}, '{10'h100, 20'h3001b, 12'h000},
      '{10'h080, 20'h5002b, 12'h040}, '{10'h040, 20'h5002b, 12'h080},
      '{10'h020, 20'h40023, 12'h010}, '{10'h010, 20'h40023, 12'h020},
      '{10'h008, 20'h60033, 12'h100}, '{10'h004, 20'h7003b, 12'h200},
      '{10'h002, 20'h80043, 12'h400}, '{10'h001, 20'h90063, 12'h800}};
   logic clk, ack, take, irq;
   logic rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ret = 1'b0;
   logic pin0 = 1'b1, pin1 = 1'b1;
   logic [7:0] adr = 8'h00, n_taken, got = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, rd_val;
   logic [3:0] sel = 4'hf, lag = 4'h0;
   logic [19:0] taken;
   irq_pkg::src_events_t src = '0;
   irq_pkg::grant_t grant;
   int mismatches = 0, n_compared = 0;
   two_level_interrupt_unit #(.CYCLE_CLKS(4)) u_dut (.clk_i(clk), .rst_i(rst),
      .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc),
      .stb_i(stb), .ack_o(ack), .ext_request_pin_0_i(pin0), .ext_request_pin_1_i(pin1),
      .src_i(src), .grant_o(grant), .take_i(take), .return_i(ret), .irq_o(irq));
   core_model u_core (.clk_i(clk), .rst_i(rst), .grant_i(grant), .lag_i(lag),
      .take_o(take), .taken_o(taken), .n_taken_o(n_taken));
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      check(32'(ack), 32'h1);
      rd_val = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(rd_val, e);
   endtask
   task automatic pulse(input logic [9:0] e);
      src <= e;
      @(posedge clk);
      src <= '0;
      @(posedge clk);
   endtask
   task automatic pulse_ret;
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      @(posedge clk);
   endtask
   task automatic expect_take(input logic [19:0] e);
      int n;
      n = 0;
      while (n_taken === got && n < 200) begin
         @(posedge clk);
         n++;
      end
      got = got + 8'h01;
      check(32'(n_taken), 32'(got));
      check(32'(taken), 32'(e));
   endtask
   task automatic no_take(input int n);
      repeat (n) @(posedge clk);
      check(32'(n_taken), 32'(got));
   endtask
   task automatic end_sim;
      $display("mismatches %0d compared %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // The run needs well under a few thousand cycles.
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      end_sim;
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      lag <= 4'h3;
      wr(8'h04, 32'h83ff);
      foreach (rows[i]) begin
         pulse(rows[i].ev);
         expect_take(rows[i].tk);
         rd_chk(8'h00, {20'h0, rows[i].fl});
         wr(8'h00, 32'h0);
         pulse_ret;
      end
      lag <= 4'h0;
      wr(8'h04, 32'h03ff);
      wr(8'h00, 32'h00c);
      no_take(10);
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h83ff);
      no_take(10);
      wr(8'h00, 32'h00c);
      expect_take(20'h20013);
      rd_chk(8'h00, 32'h008);
      pulse_ret;
      expect_take(20'h3001b);
      pulse_ret;
      wr(8'h1c, 32'h2);
      wr(8'h08, 32'h200);
      wr(8'h00, 32'h100);
      expect_take(20'h60033);
      wr(8'h00, 32'h800);
      expect_take(20'h90063);
      rd_chk(8'h10, 32'h00c0_0000);
      rd_chk(8'hd8, 32'h8);
      check(32'(irq), 32'h1);
      wr(8'h1c, 32'h0);
      check(32'(irq), 32'h0);
      wr(8'h1c, 32'h2);
      check(32'(irq), 32'h1);
      wr(8'h18, 32'h2);
      check(32'(irq), 32'h0);
      rd_chk(8'h14, 32'h1);
      wr(8'h00, 32'h002);
      pulse_ret;
      no_take(10);
      pulse_ret;
      expect_take(20'h1000b);
      pulse_ret;
      wr(8'h08, 32'h0);
      pin0 <= 1'b0;
      expect_take(20'h00003);
      rd_chk(8'h00, 32'h0);
      pulse_ret;
      no_take(20);
      pin0 <= 1'b1;
      repeat (16) @(posedge clk);
      wr(8'h0c, 32'h2);
      pin1 <= 1'b0;
      expect_take(20'h20013);
      rd_chk(8'h00, 32'h004);
      pulse_ret;
      expect_take(20'h20013);
      pin1 <= 1'b1;
      repeat (16) @(posedge clk);
      wr(8'h00, 32'h0);
      pulse_ret;
      no_take(20);
      wr(8'h08, 32'h3ff);
      wr(8'h40, 32'hff);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk(8'h08, 32'h0);
      rd_chk(8'h04, 32'h0);
      rd_chk(8'h0c, 32'h0);
      rd_chk(8'h40, 32'h0);
      rd_chk(8'h14, 32'h0);
      check(32'(grant), 32'h0);
      end_sim;
   end
endmodule
